// ==== ssr_consts.svh ====
// constants for the status, error and service-request reporter
// Behaviour
// R1: after power-up run numbered self-test steps, show each on display and bus
// R2: step one initialises and checks analog section; fault or overvoltage gives code 7
// R3: step two checks calibration memory checksum; mismatch gives code 8
// R4: step three checks program memory checksum; mismatch gives code 9
// R5: self-test reruns when program 98 is selected and compute is pressed
// R6: each error shown on display and bus as error designation plus code
// R7: measurement overflow gives code 1, calculation overflow gives code 2
// R8: vanished offset with negative reading gives 3, excessive offset gives 4
// R9: calibration nominal out of 5..100 percent or switch at measure gives 5
// R10: device message longer than 31 characters gives bus error code 6
// R11: keys have two-digit codes from 01; a press latches its code into message
// R12: key code holds until computer reads message, then reads 00
// R13: in service-request mode every key press raises a service request
// R14: request service on error, integration end, key press, or reset done
// R15: status byte flags cause: end, error, limits, reset, request, key
// R16: computer enables or disables service request by command
// R17: start mode picks request per measurement or after the set count
// R18: display text from bus shows only seven-segment renderable characters
// R19: display text and key reading only through bus commands
// R20: status bit 1 is data line 1 (lsb), bit 8 the msb
`ifndef SSR_CONSTS_SVH
`define SSR_CONSTS_SVH
`define SSR_STEP_COUNT 3'h4
`define SSR_STEP_FIRST 3'h1
`define SSR_ERR_NONE 4'h0
`define SSR_ERR_MEASURE_SWITCH_POSITION_OVF 4'h1
`define SSR_ERR_CALC_OVF 4'h2
`define SSR_ERR_OFS_GONE 4'h3
`define SSR_ERR_OFS_BIG 4'h4
`define SSR_ERR_CAL 4'h5
`define SSR_ERR_BUS 4'h6
`define SSR_ERR_ST1 4'h7
`define SSR_ERR_ST2 4'h8
`define SSR_ERR_ST3 4'h9
`define SSR_MSG_MAX 6'h1F
`define SSR_MSG_SAT 6'h3F
`define SSR_PROG_SELFTEST 8'h98
`define SSR_KEY_NONE 8'h00
`define SSR_BIT_END 0
`define SSR_BIT_ERR 3
`define SSR_BIT_LIM 4
`define SSR_BIT_RST 5
`define SSR_BIT_SRQ 6
`define SSR_BIT_KEY 7
`define SSR_CAL_LO_PCT 7'h05
`define SSR_CAL_HI_PCT 7'h64
`define SSR_CHAR_BLANK 7'h20
`endif

// ==== ssr_pkg.sv ====
// types shared by the status reporter files
package ssr_pkg;
  typedef enum logic [2:0]
  {
    SSR_IDLE = 3'b000,
    SSR_ST1 = 3'b001,
    SSR_ST2 = 3'b010,
    SSR_ST3 = 3'b011,
    SSR_ST4 = 3'b100
  } ssr_test_e;
  typedef struct packed
  {
    logic measure_switch_position_ovf;
    logic calc_ovf;
    logic ofs_gone;
    logic ofs_big;
    logic cal_range_bad;
    logic measure_switch_position;
  } ssr_err_in_s;
  typedef struct packed
  {
    logic valid;
    logic [6:0] ch;
  } ssr_char_s;
endpackage

// ==== ssr_seg_filter.sv ====
// seven-segment character filter with registered output
`timescale 1ns/10ps
`include "ssr_consts.svh"
module ssr_seg_filter
  import ssr_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire ssr_char_s char_in,
  output ssr_char_s char_out
);
  ssr_char_s next_out;
  logic ok;

  // renderable set: digits, blank, minus, point, and letters a seven-segment can draw
  always_comb
  begin
    unique case (char_in.ch)
      7'h30, 7'h31, 7'h32, 7'h33, 7'h34, 7'h35, 7'h36, 7'h37, 7'h38, 7'h39,
      7'h20, 7'h2D, 7'h2E, 7'h41, 7'h43, 7'h45, 7'h46, 7'h48, 7'h4A, 7'h4C,
      7'h50, 7'h55, 7'h62, 7'h63, 7'h64, 7'h68, 7'h6E, 7'h6F, 7'h72, 7'h74,
      7'h75:
        ok = 1'b1;
      default:
        ok = 1'b0;
    endcase
    next_out.valid = char_in.valid;
    // unrenderable characters become blanks so column positions stay intact
    next_out.ch = ok ? char_in.ch : `SSR_CHAR_BLANK; // R18
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      char_out <= '0;
    else
      char_out <= next_out;
  end
endmodule

// ==== ssr_msg_counter.sv ====
// counts received message characters and flags an overlong message
`timescale 1ns/10ps
`include "ssr_consts.svh"
module ssr_msg_counter
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic char_strobe,
  input wire logic msg_end,
  output logic too_long
);
  logic [5:0] count;
  logic [5:0] next_count;
  logic next_too_long;

  // saturating count; pulse once when char 32 arrives
  always_comb
  begin
    next_count = count;
    next_too_long = 1'b0;
    if (msg_end)
      next_count = '0;
    else if (char_strobe)
    begin
      if (count == `SSR_MSG_MAX)
        next_too_long = 1'b1; // R10
      if (count != `SSR_MSG_SAT)
        next_count = count + 6'h01;
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      count <= '0;
      too_long <= 1'b0;
    end
    else
    begin
      count <= next_count;
      too_long <= next_too_long;
    end
  end
endmodule

// ==== ssr_status_reporter.sv ====
// self-test sequencer, error latch, key latch and serial-poll status byte
`timescale 1ns/10ps
`include "ssr_consts.svh"
module ssr_status_reporter
  import ssr_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic analog_ok,
  input wire logic overvoltage,
  input wire logic cal_sum_match,
  input wire logic rom_sum_match,
  input wire logic step_done,
  input wire logic [7:0] program_number,
  input wire logic compute_key,
  input wire ssr_err_in_s err_in,
  input wire logic key_press,
  input wire logic [7:0] key_code,
  input wire logic message_read,
  input wire logic rx_char_strobe,
  input wire logic rx_msg_end,
  input wire logic srq_enable_cmd,
  input wire logic srq_disable_cmd,
  input wire logic per_measure_switch_position_mode,
  input wire logic measure_switch_position_done,
  input wire logic series_done,
  input wire logic limit_violation,
  input wire logic integration_expired,
  input wire logic display_mode,
  input wire ssr_char_s bus_char,
  input wire logic serial_poll_read,
  output logic [2:0] test_step,
  output logic test_step_strobe,
  output logic test_running,
  output logic [3:0] error_code,
  output logic error_strobe,
  output logic [7:0] message_key_code,
  output logic [7:0] service_request_status,
  output logic srq_out,
  output ssr_char_s display_char
);
  ssr_test_e state;
  ssr_test_e next_state;
  logic [2:0] next_test_step;
  logic next_test_step_strobe;
  logic next_test_running;
  logic [3:0] next_error_code;
  logic next_error_strobe;
  logic [7:0] next_message_key_code;
  logic [7:0] next_status;
  logic next_srq_out;
  logic srq_en;
  logic next_srq_en;
  logic rst_pending;
  logic next_rst_pending;
  logic bus_too_long;
  logic [3:0] raised;
  logic ev_err;
  logic ev_end;
  logic ev_key;
  logic ev_rst;
  ssr_char_s masked_char;

  ssr_msg_counter u_msg
  (
    .clock(clock),
    .arst_n(arst_n),
    .char_strobe(rx_char_strobe),
    .msg_end(rx_msg_end),
    .too_long(bus_too_long)
  );

  // front panel never reaches the display text path, only bus in display mode
  always_comb
  begin
    masked_char.valid = bus_char.valid & display_mode; // R19
    masked_char.ch = bus_char.ch;
  end

  ssr_seg_filter u_seg
  (
    .clock(clock),
    .arst_n(arst_n),
    .char_in(masked_char),
    .char_out(display_char)
  );

  // self-test sequencer; steps wait on step_done from the test engine
  always_comb
  begin
    next_state = state;
    next_test_step = test_step;
    next_test_step_strobe = 1'b0;
    next_test_running = test_running;
    next_rst_pending = rst_pending;
    raised = `SSR_ERR_NONE;
    // reset cause is flagged once, in the first idle cycle after the last step
    if (rst_pending && state == SSR_IDLE)
      next_rst_pending = 1'b0;
    unique case (state)
      SSR_IDLE:
      begin
        if (compute_key && program_number == `SSR_PROG_SELFTEST) // R5
        begin
          next_state = SSR_ST1;
          next_test_step = `SSR_STEP_FIRST;
          next_test_step_strobe = 1'b1;
          next_test_running = 1'b1;
        end
      end
      SSR_ST1:
      begin
        if (step_done)
        begin
          if (overvoltage || !analog_ok)
            raised = `SSR_ERR_ST1; // R2
          next_state = SSR_ST2;
          next_test_step = test_step + 3'h1;
          next_test_step_strobe = 1'b1; // R1
        end
      end
      SSR_ST2:
      begin
        if (step_done)
        begin
          if (!cal_sum_match)
            raised = `SSR_ERR_ST2; // R3
          next_state = SSR_ST3;
          next_test_step = test_step + 3'h1;
          next_test_step_strobe = 1'b1; // R1
        end
      end
      SSR_ST3:
      begin
        if (step_done)
        begin
          if (!rom_sum_match)
            raised = `SSR_ERR_ST3; // R4
          next_state = SSR_ST4;
          next_test_step = `SSR_STEP_COUNT;
          next_test_step_strobe = 1'b1; // R1
        end
      end
      SSR_ST4:
      begin
        if (step_done)
        begin
          next_state = SSR_IDLE;
          next_test_running = 1'b0;
          next_rst_pending = 1'b1;
        end
      end
    endcase
    // operator errors, only when no self-test code is raised; lower code wins among them
    if (raised == `SSR_ERR_NONE)
    begin
      if (err_in.measure_switch_position_ovf)
        raised = `SSR_ERR_MEASURE_SWITCH_POSITION_OVF; // R7
      else if (err_in.calc_ovf)
        raised = `SSR_ERR_CALC_OVF; // R7
      else if (err_in.ofs_gone)
        raised = `SSR_ERR_OFS_GONE; // R8
      else if (err_in.ofs_big)
        raised = `SSR_ERR_OFS_BIG; // R8
      else if (err_in.cal_range_bad || err_in.measure_switch_position)
        raised = `SSR_ERR_CAL; // R9
      else if (bus_too_long)
        raised = `SSR_ERR_BUS; // R10
    end
  end

  // error code and one strobe feed both display and bus formatter
  always_comb
  begin
    next_error_code = error_code;
    next_error_strobe = 1'b0;
    if (raised != `SSR_ERR_NONE)
    begin
      next_error_code = raised; // R6
      next_error_strobe = 1'b1; // R6
    end
  end

  // key latch; a press in the read cycle wins so no key is lost
  always_comb
  begin
    next_message_key_code = message_key_code;
    if (key_press)
      next_message_key_code = key_code; // R11
    else if (message_read)
      next_message_key_code = `SSR_KEY_NONE; // R12
  end

  // service-request enable, disable wins if both commands coincide
  always_comb
  begin
    next_srq_en = srq_en;
    if (srq_disable_cmd)
      next_srq_en = 1'b0; // R16
    else if (srq_enable_cmd)
      next_srq_en = 1'b1; // R16
  end

  // cause bits are sticky; events beat the poll-read clear
  always_comb
  begin
    ev_err = next_error_strobe;
    ev_end = (per_measure_switch_position_mode ? measure_switch_position_done : series_done) | integration_expired; // R17
    ev_key = key_press; // R13
    ev_rst = rst_pending && state == SSR_IDLE;
    next_status = service_request_status;
    if (serial_poll_read)
      next_status = 8'h00;
    if (ev_end)
      next_status[`SSR_BIT_END] = 1'b1; // R15
    if (ev_err)
      next_status[`SSR_BIT_ERR] = 1'b1; // R15
    if (limit_violation)
      next_status[`SSR_BIT_LIM] = 1'b1; // R15
    if (ev_rst)
      next_status[`SSR_BIT_RST] = 1'b1; // R15
    if (ev_key)
      next_status[`SSR_BIT_KEY] = 1'b1; // R20
    if (srq_en && (ev_end || ev_err || ev_key || ev_rst)) // R14
      next_status[`SSR_BIT_SRQ] = 1'b1;
    next_srq_out = next_status[`SSR_BIT_SRQ];
  end

  // one register stage per group; reset starts the power-on self-test
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= SSR_ST1;
      test_step <= `SSR_STEP_FIRST;
      test_step_strobe <= 1'b1;
      test_running <= 1'b1;
      rst_pending <= 1'b0;
      error_code <= `SSR_ERR_NONE;
      error_strobe <= 1'b0;
      message_key_code <= `SSR_KEY_NONE;
      srq_en <= 1'b0;
      service_request_status <= 8'h00;
      srq_out <= 1'b0;
    end
    else
    begin
      state <= next_state;
      test_step <= next_test_step;
      test_step_strobe <= next_test_step_strobe;
      test_running <= next_test_running;
      rst_pending <= next_rst_pending;
      error_code <= next_error_code;
      error_strobe <= next_error_strobe;
      message_key_code <= next_message_key_code;
      srq_en <= next_srq_en;
      service_request_status <= next_status;
      srq_out <= next_srq_out;
    end
  end
endmodule

// ==== ssr_status_reporter_assertions.sv ====
// concurrent checks on the status reporter ports
`timescale 1ns/10ps
module ssr_status_reporter_assertions
  import ssr_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic step_done,
  input wire logic cal_sum_match,
  input wire logic [7:0] program_number,
  input wire logic compute_key,
  input wire logic key_press,
  input wire logic [7:0] key_code,
  input wire logic message_read,
  input wire logic display_mode,
  input wire logic [2:0] test_step,
  input wire logic test_step_strobe,
  input wire logic test_running,
  input wire logic [3:0] error_code,
  input wire logic error_strobe,
  input wire logic [7:0] message_key_code,
  input wire logic [7:0] service_request_status,
  input wire logic srq_out,
  input wire ssr_char_s display_char
);
  // one domain, so one clock and one reset for every property
  default clocking @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  // sequencer, error, key, request-line and display behaviour tied to their causes
  a_step_advance: assert property (
    step_done && test_running && test_step < 3'h4 |=> test_step_strobe
    && test_step == $past(test_step) + 3'h1) else $error("step did not advance");
  a_selftest_rerun: assert property (
    compute_key && program_number == 8'h98 && !test_running |=> test_running
    && test_step == 3'h1) else $error("self-test not restarted");
  a_cal_sum: assert property (
    step_done && test_running && test_step == 3'h2 && !cal_sum_match
    |=> error_strobe && error_code == 4'h8) else $error("missing code 8");
  a_key_latch: assert property (
    key_press |=> message_key_code == $past(key_code) && service_request_status[7])
    else $error("key code not latched");
  a_key_clear: assert property (
    message_read && !key_press |=> message_key_code == 8'h00) else $error("key not cleared");
  a_err_flag: assert property (
    error_strobe |-> service_request_status[3]) else $error("error flag missing");
  a_srq_mirror: assert property (
    srq_out == service_request_status[6] && service_request_status[2:1] == 2'h0)
    else $error("request line and status differ");
  a_display_gate: assert property (
    !display_mode |=> !display_char.valid) else $error("text shown outside display mode");
  // main scenarios reached
  cover property (error_strobe && error_code == 4'h6);
  cover property (srq_out && service_request_status[7]);
  cover property (test_step_strobe && test_step == 3'h4);
endmodule
bind ssr_status_reporter ssr_status_reporter_assertions u_chk (.clock, .arst_n, .step_done,
  .cal_sum_match, .program_number, .compute_key, .key_press, .key_code, .message_read,
  .display_mode, .test_step, .test_step_strobe, .test_running, .error_code, .error_strobe,
  .message_key_code, .service_request_status, .srq_out, .display_char);

// ==== ssr_bus_ctrl.sv ====
// behavioural controlling computer on the instrument bus
`timescale 1ns/10ps
module ssr_bus_ctrl
  import ssr_pkg::*;
(
  input wire logic clock,
  output logic srq_enable_cmd,
  output logic srq_disable_cmd,
  output logic message_read,
  output logic serial_poll_read,
  output logic rx_msg_end,
  output logic rx_char_strobe,
  output logic display_mode,
  output ssr_char_s bus_char
);
  logic [4:0] c;
  // one command at a time, as a single talker would send them
  assign {srq_enable_cmd, srq_disable_cmd, message_read, serial_poll_read, rx_msg_end} = c;
  // idle bus at time zero
  initial
  begin
    c = 5'h00;
    rx_char_strobe = 1'b0;
    display_mode = 1'b0;
    bus_char = 8'h7F;
  end
  // delay of at least one cycle, so pulses never abut; larger means a slow host
  task automatic cmd(input logic [4:0] m, input int dly);
    repeat (dly) @(posedge clock);
    c <= m;
    @(posedge clock);
    c <= 5'h00;
    #1;
  endtask
  // text for the display goes out only in display mode
  task automatic mode(input logic m);
    @(posedge clock);
    display_mode <= m;
  endtask
  // back-to-back characters, then the lines are released
  task automatic send(input int n, input logic [6:0] ch);
    repeat (n)
    begin
      @(posedge clock);
      rx_char_strobe <= 1'b1;
      bus_char <= {1'b1, ch};
    end
    @(posedge clock);
    rx_char_strobe <= 1'b0;
    bus_char <= {1'b0, ~ch}; // released lines show no stale char
    #1;
  endtask
endmodule

// ==== ssr_status_reporter_tb.sv ====
// self-checking bench for the status and service-request reporter
`timescale 1ns/10ps
module ssr_status_reporter_tb;
  import ssr_pkg::*;
  localparam logic [4:0] OK = 5'h16;
  logic clock;
  logic arst_n;
  logic [12:0] ev;
  logic [4:0] lv;
  logic [7:0] dat;
  int n_mismatch;
  int checks;
  logic srq_enable_cmd, srq_disable_cmd, message_read, serial_poll_read, rx_msg_end;
  logic rx_char_strobe, display_mode, test_step_strobe, test_running, error_strobe, srq_out;
  logic [2:0] test_step;
  logic [3:0] error_code;
  logic [7:0] message_key_code, service_request_status;
  ssr_char_s bus_char, display_char;
  ssr_bus_ctrl u_host (.clock, .srq_enable_cmd, .srq_disable_cmd, .message_read,
    .serial_poll_read, .rx_msg_end, .rx_char_strobe, .display_mode, .bus_char);
  ssr_status_reporter u_dut (.clock, .arst_n, .analog_ok(lv[4]), .overvoltage(lv[3]),
    .cal_sum_match(lv[2]), .rom_sum_match(lv[1]), .per_measure_switch_position_mode(lv[0]), .step_done(ev[6]),
    .program_number(dat), .compute_key(ev[5]), .err_in(ev[12:7]), .key_press(ev[4]),
    .key_code(dat), .message_read, .rx_char_strobe, .rx_msg_end, .srq_enable_cmd,
    .srq_disable_cmd, .measure_switch_position_done(ev[3]), .series_done(ev[2]), .limit_violation(ev[1]),
    .integration_expired(ev[0]), .display_mode, .bus_char, .serial_poll_read, .test_step,
    .test_step_strobe, .test_running, .error_code, .error_strobe, .message_key_code,
    .service_request_status, .srq_out, .display_char);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one event pulse with its levels, results read once they settle
  task automatic go(input logic [12:0] m, input logic [4:0] l, input logic [7:0] d);
    @(posedge clock);
    ev <= m;
    lv <= l;
    dat <= d;
    @(posedge clock);
    ev <= 13'h0000;
    #1;
  endtask
  task automatic t_power_on();
    for (int s = 2; s <= 4; s++)
    begin
      go(13'h0040, OK, 8'h00);
      chk({test_step_strobe, 4'h0, test_step}, {5'h10, 3'(s)});
    end
    go(13'h0040, OK, 8'h00);
    chk({7'h00, test_running}, 8'h00);
    @(posedge clock);
    #1;
    chk(service_request_status, 8'h20);
  endtask
  task automatic t_faults();
    logic [4:0] bad [3] = '{5'h06, 5'h12, 5'h14};
    go(13'h0020, OK, 8'h97);
    chk({7'h00, test_running}, 8'h00);
    for (int r = 0; r < 2; r++)
    begin
      go(13'h0020, OK, 8'h98);
      chk({5'h00, test_step}, 8'h01);
      for (int s = 0; s < 3; s++)
      begin
        go(13'h0040, (r == 1 && s == 0) ? 5'h1E : bad[s], 8'h98);
        chk({error_strobe, 3'h0, error_code}, 8'h87 + 8'(s));
      end
      go(13'h0040, OK, 8'h98);
    end
  endtask
  task automatic t_errors();
    for (int i = 0; i < 6; i++)
    begin
      go(13'h1000 >> i, OK, 8'h00);
      chk({error_strobe, 3'h0, error_code}, {4'h8, (i < 5) ? 4'(i + 1) : 4'h5});
    end
    chk(service_request_status & 8'h08, 8'h08);
  endtask
  // 31 characters are legal, the 32nd is not
  task automatic t_bus_msg();
    u_host.send(31, 7'h41);
    u_host.cmd(5'h01, 1);
    chk({4'h0, error_code}, 8'h05);
    u_host.send(32, 7'h41);
    @(posedge clock);
    #1;
    chk({4'h0, error_code}, 8'h06);
    u_host.cmd(5'h01, 1);
  endtask
  task automatic t_keys();
    u_host.cmd(5'h10, 3);
    go(13'h0010, OK, 8'h01);
    chk(message_key_code, 8'h01);
    chk({srq_out, service_request_status[7:6], 5'h00}, 8'hE0);
    u_host.cmd(5'h02, 1);
    chk(service_request_status, 8'h00);
    chk(message_key_code, 8'h01);
    u_host.cmd(5'h04, 2);
    chk(message_key_code, 8'h00);
    u_host.cmd(5'h08, 1);
    go(13'h0010, OK, 8'h42);
    chk(service_request_status, 8'h80);
  endtask
  task automatic t_end();
    logic [12:0] e [6] = '{13'h0008, 13'h0008, 13'h0004, 13'h0001, 13'h0002, 13'h1000};
    logic [7:0] x [6] = '{8'h41, 8'h00, 8'h41, 8'h41, 8'h10, 8'h48};
    u_host.cmd(5'h10, 1);
    for (int i = 0; i < 6; i++)
    begin
      u_host.cmd(5'h02, 2);
      go(e[i], (i == 0) ? 5'h17 : OK, 8'h00);
      chk(service_request_status, x[i]);
    end
  endtask
  task automatic t_display();
    u_host.mode(1'b1);
    u_host.send(1, 7'h41);
    chk(display_char, 8'hC1);
    u_host.send(1, 7'h4B);
    chk(display_char, 8'hA0);
    u_host.mode(1'b0);
    u_host.send(1, 7'h41);
    chk(display_char & 8'h80, 8'h00);
  endtask
  task automatic close_out();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // free-running clock
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // reset, then the scenarios in order; later ones rely on earlier codes
  initial
  begin
    arst_n = 1'b0;
    ev = 13'h0000;
    lv = OK;
    dat = 8'h00;
    n_mismatch = 0;
    checks = 0;
    repeat (5) @(posedge clock);
    arst_n <= 1'b1;
    t_power_on();
    t_faults();
    t_errors();
    t_bus_msg();
    t_keys();
    t_end();
    t_display();
    close_out();
  end
endmodule
